// ===== pkg/gidb_defines.svh
// Purpose: offsets, field positions and reset values of the debounce block
// Assumes: 32-bit classic wishbone, byte addresses
// Notes:   definitions only
`ifndef GIDB_DEFINES_SVH
`define GIDB_DEFINES_SVH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define GIDB_OFF_DBNC_CTRL   12'h180
`define GIDB_OFF_PIN_IEN     12'h184
`define GIDB_OFF_SRC_FLAG    12'h188
`define GIDB_OFF_PIN_SAMPLE  12'h18C

// ----------------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------------
`define GIDB_SEL_LSB         0
`define GIDB_SEL_MSB         3
`define GIDB_CLK_SRC_BIT     4
`define GIDB_ALWAYS_ON_BIT   5
`define GIDB_CTRL_RST        32'h0000_0020
`define GIDB_IEN_RST         16'h0000
`define GIDB_FLAG_RST        16'h0000

// ----------------------------------------------------------------------
// widths
// ----------------------------------------------------------------------
`define GIDB_NPINS           16
`define GIDB_CNT_W           15

`endif

// ===== pkg/gidb_pkg.sv
// Purpose: types shared by the debounce block
// Assumes: fields as laid out in gidb_defines.svh
// Notes:   nothing is imported elsewhere
package gidb_pkg;

    // ------------------------------------------------------------------
    // control register layout
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [25:0] reserved;
        logic        edge_detect_always_on;
        logic        debounce_clock_source_select;
        logic [3:0]  sample_interval_select;
    } gidb_ctrl_t;

    // ------------------------------------------------------------------
    // one wishbone request as seen by the slave
    // ------------------------------------------------------------------
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [3:0]  sel;
        logic [11:0] adr;
        logic [31:0] dat;
    } gidb_wb_req_t;

endpackage

// ===== hw/gidb_top.sv
// Purpose: de-bounce sampling and pin edge detection ahead of pin interrupts
// Assumes: pins and the 10 kHz oscillator level are synchronous to clock
// Notes:   registers reached over a classic wishbone slave
// Operation
// - with always-on clear, a pin's detector runs only while its enable is 1.
// - with always-on set, every pin's detector runs from reset onward.
// - source bit picks bus clock (0) or 10 kHz oscillator (1) for counter.
// - interval codes 0 to 8 sample every 2**code debounce clocks.
// - interval codes 9 to 15 sample every 2 to 128 times 256 clocks.
// - control register at 0x180, resets to 0x20.
// - source flag reads 1 after an interrupt; writing 1 clears, 0 ignored.
`timescale 1ns/1ps
`include "gidb_defines.svh"
`default_nettype none

module gidb_top (
    // clock and reset
    input  wire logic                      clock,
    input  wire logic                      rst,
    // wishbone slave
    input  wire logic                      wb_cyc_i,
    input  wire logic                      wb_stb_i,
    input  wire logic                      wb_we_i,
    input  wire logic [3:0]                wb_sel_i,
    input  wire logic [11:0]               wb_adr_i,
    input  wire logic [31:0]               wb_dat_i,
    output var  logic [31:0]               wb_dat_o,
    output var  logic                      wb_ack_o,
    // pins and low-speed oscillator
    input  wire logic [`GIDB_NPINS-1:0]    pin_in,
    input  wire logic                      lirc_clk_in,
    // interrupt side
    output var  logic [`GIDB_NPINS-1:0]    src_flag_o,
    output var  logic                      irq_o
);

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------

    // byte-enable to bit mask
    function automatic logic [31:0] lane_mask(input logic [3:0] sel);
        logic [31:0] m;
        m = 32'h0000_0000;
        for (int b = 0; b < 4; b++) begin
            m[b*8 +: 8] = {8{sel[b]}};
        end
        return m;
    endfunction

    // interval code to counter mask: all codes give 2**code clocks
    function automatic logic [`GIDB_CNT_W-1:0] interval_mask(input logic [3:0] code);
        logic [`GIDB_CNT_W:0] one_hot;
        one_hot = {{`GIDB_CNT_W{1'b0}}, 1'b1} << code;
        return one_hot[`GIDB_CNT_W-1:0] - {{(`GIDB_CNT_W-1){1'b0}}, 1'b1};
    endfunction

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    gidb_pkg::gidb_ctrl_t              ctrl_r;
    gidb_pkg::gidb_wb_req_t            req;
    logic [`GIDB_NPINS-1:0]            ien_r;
    logic [`GIDB_NPINS-1:0]            flag_r;
    logic [`GIDB_NPINS-1:0]            sample_r;
    logic [`GIDB_NPINS-1:0]            valid_r;
    logic [`GIDB_NPINS-1:0]            edge_hit;
    logic [`GIDB_NPINS-1:0]            w1c;
    logic [`GIDB_CNT_W-1:0]            cnt_r;
    logic [`GIDB_CNT_W-1:0]            cnt_nxt;
    logic                              lirc_prev_r;
    logic                              dbnc_tick;
    logic                              sample_stb;
    logic                              acc;
    logic                              wr;
    logic [31:0]                       wmask;
    logic [31:0]                       rdata;

    // ------------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------------

    // gather the request and qualify a fresh access
    assign req   = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i, sel: wb_sel_i,
                     adr: wb_adr_i, dat: wb_dat_i};
    assign acc   = req.cyc && req.stb && !wb_ack_o;
    assign wr    = acc && req.we;
    assign wmask = lane_mask(req.sel);

    // write-one-to-clear lanes for the flag register
    assign w1c = (wr && req.adr == `GIDB_OFF_SRC_FLAG)
               ? (req.dat[`GIDB_NPINS-1:0] & wmask[`GIDB_NPINS-1:0])
               : {`GIDB_NPINS{1'b0}};

    // read mux, unmapped reads as zero
    always_comb begin
        rdata = 32'h0000_0000;
        unique case (req.adr)
            `GIDB_OFF_DBNC_CTRL:  rdata = ctrl_r;
            `GIDB_OFF_PIN_IEN:    rdata = {16'h0000, ien_r};
            `GIDB_OFF_SRC_FLAG:   rdata = {16'h0000, flag_r};
            `GIDB_OFF_PIN_SAMPLE: rdata = {16'h0000, sample_r};
            default:              rdata = 32'h0000_0000;
        endcase
    end

    // ------------------------------------------------------------------
    // bus answer
    // ------------------------------------------------------------------

    // one-cycle ack for every access, mapped or not
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= acc;
        end
    end

    // read data captured with the ack
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (acc) begin
            wb_dat_o <= req.we ? 32'h0000_0000 : rdata;
        end
    end

    // ------------------------------------------------------------------
    // registers written by software
    // ------------------------------------------------------------------

    // debounce control, low byte only holds fields
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ctrl_r <= `GIDB_CTRL_RST;
        end else if (wr && req.adr == `GIDB_OFF_DBNC_CTRL && req.sel[0]) begin
            ctrl_r.edge_detect_always_on        <= req.dat[`GIDB_ALWAYS_ON_BIT];
            ctrl_r.debounce_clock_source_select <= req.dat[`GIDB_CLK_SRC_BIT];
            ctrl_r.sample_interval_select       <= req.dat[`GIDB_SEL_MSB:`GIDB_SEL_LSB];
        end
    end

    // per-pin interrupt enables
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ien_r <= `GIDB_IEN_RST;
        end else if (wr && req.adr == `GIDB_OFF_PIN_IEN) begin
            ien_r <= (ien_r & ~wmask[`GIDB_NPINS-1:0])
                   | (req.dat[`GIDB_NPINS-1:0] & wmask[`GIDB_NPINS-1:0]);
        end
    end

    // ------------------------------------------------------------------
    // debounce clock and sampling strobe
    // ------------------------------------------------------------------

    // previous oscillator level for rise detection
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            lirc_prev_r <= 1'b0;
        end else begin
            lirc_prev_r <= lirc_clk_in;
        end
    end

    // bus clock ticks every cycle, oscillator ticks on its rise
    assign dbnc_tick = ctrl_r.debounce_clock_source_select
                     ? (lirc_clk_in && !lirc_prev_r)
                     : 1'b1;

    // sample when the low bits of the count are all ones
    assign sample_stb = dbnc_tick
        && ((cnt_r & interval_mask(ctrl_r.sample_interval_select))
            == interval_mask(ctrl_r.sample_interval_select));
    assign cnt_nxt = cnt_r + {{(`GIDB_CNT_W-1){1'b0}}, 1'b1};

    // free-running debounce counter
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cnt_r <= {`GIDB_CNT_W{1'b0}};
        end else if (dbnc_tick) begin
            cnt_r <= cnt_nxt;
        end
    end

    // ------------------------------------------------------------------
    // per-pin edge detectors
    // ------------------------------------------------------------------
    for (genvar i = 0; i < `GIDB_NPINS; i++) begin : g_pin
        logic active;

        // detector runs when always-on or the pin is enabled
        assign active = ctrl_r.edge_detect_always_on || ien_r[i];

        // edge only between two consecutive valid samples
        assign edge_hit[i] = sample_stb && active && valid_r[i]
                           && (sample_r[i] != pin_in[i]);

        // sample and validity; an idle detector forgets its history
        always_ff @(posedge clock or posedge rst) begin
            if (rst) begin
                sample_r[i] <= 1'b0;
                valid_r[i]  <= 1'b0;
            end else if (!active) begin
                valid_r[i]  <= 1'b0;
            end else if (sample_stb) begin
                sample_r[i] <= pin_in[i];
                valid_r[i]  <= 1'b1;
            end
        end

        // source flag: a new edge wins over a write-one clear
        always_ff @(posedge clock or posedge rst) begin
            if (rst) begin
                flag_r[i] <= 1'b0;
            end else if (edge_hit[i] && ien_r[i]) begin
                flag_r[i] <= 1'b1;
            end else if (w1c[i]) begin
                flag_r[i] <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // outputs from flip-flops
    // ------------------------------------------------------------------

    // flags and combined request, both one cycle behind flag_r
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            src_flag_o <= {`GIDB_NPINS{1'b0}};
            irq_o      <= 1'b0;
        end else begin
            src_flag_o <= flag_r;
            irq_o      <= |flag_r;
        end
    end

endmodule // gidb_top

`default_nettype wire

// ===== tb/gidb_asserts.sv
// Purpose: bus and flag checks on gidb_top ports
// Assumes: one clock domain, async active-high rst
// Notes:   bound to every gidb_top below
`timescale 1ns/1ps
`include "gidb_defines.svh"
`default_nettype none

module gidb_asserts (
    // clock, reset and bus
    input wire logic                   clock,
    input wire logic                   rst,
    input wire logic                   wb_cyc_i,
    input wire logic                   wb_stb_i,
    input wire logic                   wb_we_i,
    input wire logic [3:0]             wb_sel_i,
    input wire logic [11:0]            wb_adr_i,
    input wire logic [31:0]            wb_dat_i,
    input wire logic [31:0]            wb_dat_o,
    input wire logic                   wb_ack_o,
    // pins and flags
    input wire logic [`GIDB_NPINS-1:0] pin_in,
    input wire logic                   lirc_clk_in,
    input wire logic [`GIDB_NPINS-1:0] src_flag_o,
    input wire logic                   irq_o
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    // request taken, and a read of one address
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_rd(a);
        s_req ##0 (!wb_we_i && wb_adr_i == a);
    endsequence
    AST_ACK_NEXT: assert property (s_req |=> wb_ack_o)
        else $error("ack missing after request");
    AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    AST_ACK_CAUSE: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    AST_CTRL_RSV: assert property (s_rd(`GIDB_OFF_DBNC_CTRL) |=> wb_dat_o[31:6] == 26'h0)
        else $error("control upper bits not zero");
    AST_UNMAP_ZERO: assert property (s_req ##0 (!wb_we_i && wb_adr_i[11:4] != 8'h18)
        |=> wb_dat_o == 32'h0) else $error("unmapped read not zero");
    AST_WR_ZERO: assert property (s_req ##0 wb_we_i |=> wb_ack_o && wb_dat_o == 32'h0)
        else $error("write returned data");
    AST_IRQ_OR: assert property (irq_o == |src_flag_o)
        else $error("irq differs from flags");
    AST_FLAG_CLR: assert property (|($past(src_flag_o) & ~src_flag_o)
        |-> $past(wb_cyc_i && wb_stb_i && wb_we_i && wb_adr_i == `GIDB_OFF_SRC_FLAG, 2))
        else $error("flag fell without clear");
endmodule // gidb_asserts

bind gidb_top gidb_asserts chk_u (.clock, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_sel_i,
    .wb_adr_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .pin_in, .lirc_clk_in, .src_flag_o, .irq_o);
`default_nettype wire

// ===== tb/gidb_pin_model.sv
// Purpose: pin levels and low-speed oscillator in front of gidb_top
// Assumes: bench asks for pin flips one cycle at a time
// Notes:   HALF sets the oscillator half period in clocks
`timescale 1ns/1ps
`default_nettype none

module gidb_pin_model #(
    parameter int HALF = 5000
) (
    // clock and reset
    input  wire logic        clock,
    input  wire logic        rst,
    // flip request and outputs
    input  wire logic [15:0] tgl,
    output var  logic [15:0] pin_in,
    output var  logic        lirc_clk_in
);
    int cnt;
    // pins flip where asked
    always_ff @(posedge clock or posedge rst) begin
        if (rst) pin_in <= '0;
        else pin_in <= pin_in ^ tgl;
    end
    // free running oscillator level
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cnt <= 0;
            lirc_clk_in <= 1'b0;
        end else if (cnt == HALF - 1) begin
            cnt <= 0;
            lirc_clk_in <= ~lirc_clk_in;
        end else cnt <= cnt + 1;
    end
endmodule // gidb_pin_model
`default_nettype wire

// ===== tb/gidb_top_tb.sv
// Purpose: self-checking bench for gidb_top
// Assumes: pin model drives pins and oscillator
// Notes:   sample period measured from the second pin flip to its flag
`timescale 1ns/1ps
`include "gidb_defines.svh"
`default_nettype none
`define CHK(a, b) begin num_checks++; \
    if ((a) !== (b)) begin fail_count++; \
    $display("[FAIL] %0t got %0h exp %0h", $time, (a), (b)); end end

module gidb_top_tb;
    localparam int HALF = 8;
    logic                   clock = 1'b0;
    logic                   rst = 1'b1;
    gidb_pkg::gidb_wb_req_t req = '0;
    logic [31:0]            dat_o, d;
    logic                   ack, lirc, irq;
    logic [15:0]            pins, flags;
    logic [15:0]            tgl = '0;
    int                     fail_count = 0;
    int                     num_checks = 0;
    int                     n;
    // clock
    always #5 clock = ~clock;
    gidb_top dut_u (.clock, .rst, .wb_cyc_i(req.cyc), .wb_stb_i(req.stb), .wb_we_i(req.we),
        .wb_sel_i(req.sel), .wb_adr_i(req.adr), .wb_dat_i(req.dat), .wb_dat_o(dat_o),
        .wb_ack_o(ack), .pin_in(pins), .lirc_clk_in(lirc), .src_flag_o(flags), .irq_o(irq));
    gidb_pin_model #(.HALF(HALF)) pin_u (.clock, .rst, .tgl, .pin_in(pins), .lirc_clk_in(lirc));
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic timeout();
        fail_count++;
        $display("[FAIL] %0t no answer", $time);
        tally_and_finish();
    endtask
    // one classic cycle, held until ack
    task automatic wb_xfer(input logic we, input logic [11:0] a, input logic [31:0] v,
                           output logic [31:0] r);
        int t;
        t = 0;
        @(posedge clock);
        req <= '{1'b1, 1'b1, we, 4'hF, a, v};
        do begin
            @(posedge clock);
            t++;
        end while (ack !== 1'b1 && t < 100);
        r = dat_o;
        req <= '0;
        if (t >= 100) timeout();
    endtask
    task automatic flip(input logic [15:0] m);
        tgl <= m;
        @(posedge clock);
        tgl <= '0;
    endtask
    task automatic wait_flag(input int b);
        n = 0;
        do begin
            @(posedge clock);
            #1;
            n++;
        end while (flags[b] !== 1'b1 && n < 40000);
        if (n >= 40000) timeout();
    endtask
    // cycles from second flip to its flag
    function automatic int lat(input int per);
        return (3 / per + 1) * per - 2;
    endfunction
    task automatic measure(input logic src, input logic [3:0] c, input int per);
        // even codes run with always-on clear, so only the enables keep detectors up
        wb_xfer(1'b1, `GIDB_OFF_DBNC_CTRL, {26'h0, c[0], src, c}, d);
        wb_xfer(1'b1, `GIDB_OFF_SRC_FLAG, 32'h0000_0003, d);
        flip(16'h0001);
        wait_flag(0);
        @(posedge clock);
        flip(16'h0002);
        wait_flag(1);
        `CHK(n, lat(per))
    endtask
    // main sequence
    initial begin
        void'($urandom(5));
        repeat (5) @(posedge clock);
        rst <= 1'b0;
        wb_xfer(1'b0, `GIDB_OFF_DBNC_CTRL, 32'h0, d);
        `CHK(d, `GIDB_CTRL_RST)
        wb_xfer(1'b0, 12'h1F0, 32'h0, d);
        `CHK(d, 32'h0000_0000)
        repeat (6) begin
            n = $urandom;
            wb_xfer(1'b1, `GIDB_OFF_DBNC_CTRL, n, d);
            wb_xfer(1'b0, `GIDB_OFF_DBNC_CTRL, 32'h0, d);
            `CHK(d, n & 32'h0000_003F)
        end
        wb_xfer(1'b1, `GIDB_OFF_DBNC_CTRL, 32'h0, d);
        flip(16'h0008);
        repeat (4) @(posedge clock);
        wb_xfer(1'b0, `GIDB_OFF_PIN_SAMPLE, 32'h0, d);
        `CHK(d[3], 1'b0)
        wb_xfer(1'b1, `GIDB_OFF_DBNC_CTRL, 32'h0000_0020, d);
        repeat (4) @(posedge clock);
        wb_xfer(1'b0, `GIDB_OFF_PIN_SAMPLE, 32'h0, d);
        `CHK(d[3], 1'b1)
        wb_xfer(1'b1, `GIDB_OFF_PIN_IEN, 32'h0000_FFFF, d);
        for (int c = 0; c < 15; c++) measure(1'b0, c[3:0], 1 << c);
        measure(1'b1, 4'h0, 2 * HALF);
        measure(1'b1, 4'h1, 4 * HALF);
        wb_xfer(1'b1, `GIDB_OFF_SRC_FLAG, 32'h0000_0001, d);
        wb_xfer(1'b0, `GIDB_OFF_SRC_FLAG, 32'h0, d);
        `CHK(d, 32'h0000_0002)
        `CHK(irq, 1'b1)
        // clear the last flag; outputs follow two edges later
        wb_xfer(1'b1, `GIDB_OFF_SRC_FLAG, 32'h0000_0002, d);
        repeat (2) @(posedge clock);
        `CHK({irq, flags}, 17'h0_0000)
        wb_xfer(1'b1, `GIDB_OFF_DBNC_CTRL, 32'h0, d);
        tally_and_finish();
    end
endmodule // gidb_top_tb
`default_nettype wire
